// file: rtl/sdram_pkg.sv
// Purpose: shared constants, pin bundle and command codes for the sdram core
// Assumes: all pins sampled on the rising edge of the system clock
// Notes:   cycle counts are for the fastest speed grade

package sdram_pkg;

  localparam int DQ_W     = 16;
  localparam int ADDR_W   = 12;
  localparam int ROW_W    = 11;
  localparam int COL_W    = 10;
  localparam int BANK_BIT = 11;
  localparam int AP_BIT   = 10;

  // command spacing in clock cycles
  localparam int CAS_LAT  = 3;
  localparam int RCD_CYC  = 3;
  localparam int RC_CYC   = 9;
  localparam int RAS_CYC  = 6;
  localparam int RP_CYC   = 3;
  localparam int RRD_CYC  = 3;
  localparam int CCD_CYC  = 1;
  localparam int DPL_CYC  = 1;
  localparam int DAL_CYC  = 4;
  localparam int RBD_CYC  = 3;
  localparam int WBD_CYC  = 0;
  localparam int ROH_CYC  = 3;
  localparam int WDL_CYC  = 0;
  localparam int QMD_CYC  = 2;
  localparam int DMD_CYC  = 0;
  localparam int MCD_CYC  = 2;

  // clock-enable recovery is one clock plus a fixed time, rounded up
  localparam int CLK_MHZ  = 25;
  localparam int TCKA_NS  = 3;
  localparam int CKA_CYC  = 1 + (TCKA_NS * CLK_MHZ + 999) / 1000;

  localparam logic [ADDR_W-1:0] MODE_RST   = 12'h000;
  localparam logic [ROW_W-1:0]  REF_ROW_RST = 11'h000;
  localparam logic              CKE_RST    = 1'b0;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [1:0]        dqm;
    logic [ADDR_W-1:0] addr;
  } pins_type;

  typedef enum logic [3:0] {
    CMD_DESL  = 4'h0,
    CMD_NOP   = 4'h1,
    CMD_BST   = 4'h2,
    CMD_READ  = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_ACT   = 4'h5,
    CMD_PRE   = 4'h6,
    CMD_REF   = 4'h7,
    CMD_MRS   = 4'h8
  } cmd_type;

  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_SELF = 1'b1
  } power_type;

  function automatic cmd_type decode_cmd(input pins_type p);
    cmd_type c;
    c = CMD_NOP;
    casez ({p.cs_n, p.ras_n, p.cas_n, p.we_n})
      4'b1???: c = CMD_DESL;
      4'b0111: c = CMD_NOP;
      4'b0110: c = CMD_BST;
      4'b0101: c = CMD_READ;
      4'b0100: c = CMD_WRITE;
      4'b0011: c = CMD_ACT;
      4'b0010: c = CMD_PRE;
      4'b0001: c = CMD_REF;
      default: c = CMD_MRS;
    endcase
    return c;
  endfunction : decode_cmd

endpackage : sdram_pkg

// file: rtl/sdram_device.sv
// Purpose: command decode, bank state, bursts and data path of a two-bank
//          sixteen-bit synchronous dram
// Assumes: the controller runs on i_clk_sys, so pins need no synchroniser
// Notes:   the storage array keeps only a few row bits per bank
//
// Summary of operation
// - read data appears three cycles after command
// - column commands accepted every cycle
// - burst stop: read hi-z after three, write ignored
// - precharge ends read after three, write at once
// - mask blanks read two later, write same cycle
// - mode load from address pins when banks idle
// - activate opens row in selected bank
// - precharge closes one bank or both
// - read bursts from selected open bank column
// - auto-precharge closes bank at burst end
// - refresh when idle, blocks commands eight cycles
// - self-refresh while clock-enable low, then busy
// - clock-enable low freezes; recovery delay on exit

`timescale 1ns/1ps
`default_nettype none

module sdram_device #(
  parameter int BURST_LEN = 4,
  parameter int ROW_USE   = 2
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  input  wire sdram_pkg::pins_type         i_pins,
  input  wire logic                        i_cke,
  input  wire logic [sdram_pkg::DQ_W-1:0]  i_dq,
  output logic      [sdram_pkg::DQ_W-1:0]  o_dq,
  output logic      [1:0]                  o_dq_oe,
  output logic      [1:0]                  o_bank_open,
  output logic      [sdram_pkg::ADDR_W-1:0] o_mode,
  output logic      [sdram_pkg::ROW_W-1:0] o_refresh_row,
  output logic                             o_self_refresh,
  output logic                             o_busy
);

  localparam int LB      = (BURST_LEN > 1) ? $clog2(BURST_LEN) : 1;
  localparam int CNT_W   = LB + 1;
  localparam int MEM_AW  = 1 + ROW_USE + sdram_pkg::COL_W;
  localparam int BUSY_W  = $clog2(sdram_pkg::RC_CYC);
  localparam int REC_W   = $clog2(sdram_pkg::CKA_CYC + 1);
  localparam logic [BUSY_W-1:0] RC_LOAD  = BUSY_W'(sdram_pkg::RC_CYC - 1);
  localparam logic [REC_W-1:0]  CKA_LOAD = REC_W'(sdram_pkg::CKA_CYC - 1);
  localparam logic [CNT_W-1:0]  LAST_CNT = CNT_W'(BURST_LEN - 1);
  localparam int COL_W = sdram_pkg::COL_W;

  // registered state
  logic                      cke_prev;
  sdram_pkg::power_type      pstate;
  logic [BUSY_W-1:0]         busy;
  logic [REC_W-1:0]          recov;
  logic [1:0]                open;
  logic [sdram_pkg::ROW_W-1:0] row [2];
  logic [sdram_pkg::ADDR_W-1:0] mode;
  logic [sdram_pkg::ROW_W-1:0] ref_row;
  logic                      b_act;
  logic                      b_wr;
  logic                      b_bank;
  logic                      b_ap;
  logic [COL_W-1:0]          b_col;
  logic [CNT_W-1:0]          b_cnt;
  logic                      p1_v;
  logic                      p2_v;
  logic [1:0]                p2_m;
  logic [sdram_pkg::DQ_W-1:0] p2_d;
  logic [sdram_pkg::DQ_W-1:0] rd_data;

  // next values
  logic                      next_cke_prev;
  sdram_pkg::power_type      next_pstate;
  logic [BUSY_W-1:0]         next_busy;
  logic [REC_W-1:0]          next_recov;
  logic [1:0]                next_open;
  logic [sdram_pkg::ROW_W-1:0] next_row [2];
  logic [sdram_pkg::ADDR_W-1:0] next_mode;
  logic [sdram_pkg::ROW_W-1:0] next_ref_row;
  logic                      next_b_act;
  logic                      next_b_wr;
  logic                      next_b_bank;
  logic                      next_b_ap;
  logic [COL_W-1:0]          next_b_col;
  logic [CNT_W-1:0]          next_b_cnt;
  logic                      next_p1_v;
  logic                      next_p2_v;
  logic [1:0]                next_p2_m;
  logic [sdram_pkg::DQ_W-1:0] next_p2_d;
  logic [sdram_pkg::DQ_W-1:0] next_dq;
  logic [1:0]                next_dq_oe;

  // decoded command and burst word generated this cycle
  sdram_pkg::cmd_type        cmd;
  logic                      freeze;
  logic                      cmd_bank;
  logic                      cmd_ap;
  logic                      col_cmd;
  logic                      stop;
  logic                      gen_v;
  logic                      gen_wr;
  logic                      gen_bank;
  logic                      gen_ap;
  logic                      gen_last;
  logic [COL_W-1:0]          gen_base;
  logic [CNT_W-1:0]          gen_cnt;
  logic [COL_W-1:0]          gen_col;
  logic [MEM_AW-1:0]         gen_idx;

  always_comb begin
    // with clock-enable low last edge the core is frozen
    freeze   = !cke_prev;
    cmd      = sdram_pkg::decode_cmd(i_pins);
    if (freeze || pstate != sdram_pkg::ST_RUN || busy != '0 ||
        recov != '0) begin
      cmd = sdram_pkg::CMD_NOP;
    end
    cmd_bank = i_pins.addr[sdram_pkg::BANK_BIT];
    cmd_ap   = i_pins.addr[sdram_pkg::AP_BIT];
    // column commands to a closed bank are dropped
    col_cmd  = (cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE)
               && open[cmd_bank];
    stop     = (cmd == sdram_pkg::CMD_BST) ||
               (cmd == sdram_pkg::CMD_PRE && (cmd_ap || cmd_bank == b_bank));
    // a new column command cuts the running burst
    gen_v    = !freeze && (col_cmd || (b_act && !stop));
    gen_wr   = col_cmd ? (cmd == sdram_pkg::CMD_WRITE) : b_wr;
    gen_bank = col_cmd ? cmd_bank : b_bank;
    gen_ap   = col_cmd ? cmd_ap : b_ap;
    gen_base = col_cmd ? i_pins.addr[COL_W-1:0] : b_col;
    gen_cnt  = col_cmd ? '0 : b_cnt;
    gen_last = (gen_cnt == LAST_CNT);
    // sequential wrap inside the aligned burst
    gen_col  = gen_base;
    if (BURST_LEN > 1) begin
      gen_col[LB-1:0] = gen_base[LB-1:0] + gen_cnt[LB-1:0];
    end
    gen_idx  = {gen_bank, row[gen_bank][ROW_USE-1:0], gen_col};
  end

  always_comb begin
    next_cke_prev = i_cke;
    next_pstate   = pstate;
    next_busy     = (busy != '0) ? busy - 1'b1 : busy;
    next_recov    = (recov != '0) ? recov - 1'b1 : recov;
    next_open     = open;
    next_row      = row;
    next_mode     = mode;
    next_ref_row  = ref_row;
    next_b_act    = b_act;
    next_b_wr     = b_wr;
    next_b_bank   = b_bank;
    next_b_ap     = b_ap;
    next_b_col    = b_col;
    next_b_cnt    = b_cnt;
    next_p1_v     = p1_v;
    next_p2_v     = p2_v;
    next_p2_m     = p2_m;
    next_p2_d     = p2_d;
    next_dq       = o_dq;
    next_dq_oe    = o_dq_oe;
    if (freeze) begin
      if (i_cke) begin
        if (pstate == sdram_pkg::ST_SELF) begin
          next_pstate = sdram_pkg::ST_RUN;
          next_busy   = RC_LOAD;
        end else begin
          next_recov  = CKA_LOAD;
        end
      end
    end else begin
      next_b_act = gen_v && !gen_last;
      if (gen_v) begin
        next_b_wr   = gen_wr;
        next_b_bank = gen_bank;
        next_b_ap   = gen_ap;
        next_b_col  = gen_base;
        next_b_cnt  = gen_cnt + 1'b1;
      end
      if (gen_v && gen_last && gen_ap) begin
        next_open[gen_bank] = 1'b0;
      end
      unique case (cmd)
        sdram_pkg::CMD_ACT: begin
          if (!open[cmd_bank]) begin
            next_open[cmd_bank] = 1'b1;
            next_row[cmd_bank]  = i_pins.addr[sdram_pkg::ROW_W-1:0];
          end
        end
        sdram_pkg::CMD_PRE: begin
          if (cmd_ap) begin
            next_open = 2'h0;
          end else begin
            next_open[cmd_bank] = 1'b0;
          end
        end
        sdram_pkg::CMD_REF: begin
          if (open == 2'h0) begin
            if (i_cke) begin
              next_busy    = RC_LOAD;
              next_ref_row = ref_row + 1'b1;
            end else begin
              next_pstate  = sdram_pkg::ST_SELF;
            end
          end
        end
        sdram_pkg::CMD_MRS: begin
          if (open == 2'h0) begin
            next_mode = i_pins.addr;
          end
        end
        sdram_pkg::CMD_DESL, sdram_pkg::CMD_NOP, sdram_pkg::CMD_BST,
        sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
        end
      endcase
      // three-stage read pipe; fixed for latency 3 and mask delay 2
      next_p1_v  = gen_v && !gen_wr;
      next_p2_v  = p1_v;
      next_p2_m  = i_pins.dqm;
      next_p2_d  = rd_data;
      next_dq    = p2_d;
      next_dq_oe = {2{p2_v}} & ~p2_m;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cke_prev <= sdram_pkg::CKE_RST;
      pstate   <= sdram_pkg::ST_RUN;
      busy     <= '0;
      recov    <= '0;
      open     <= 2'h0;
      row[0]   <= '0;
      row[1]   <= '0;
      mode     <= sdram_pkg::MODE_RST;
      ref_row  <= sdram_pkg::REF_ROW_RST;
      b_act    <= 1'b0;
      b_wr     <= 1'b0;
      b_bank   <= 1'b0;
      b_ap     <= 1'b0;
      b_col    <= '0;
      b_cnt    <= '0;
      p1_v     <= 1'b0;
      p2_v     <= 1'b0;
      p2_m     <= 2'h0;
      p2_d     <= '0;
      o_dq     <= '0;
      o_dq_oe  <= 2'h0;
    end else begin
      cke_prev <= next_cke_prev;
      pstate   <= next_pstate;
      busy     <= next_busy;
      recov    <= next_recov;
      open     <= next_open;
      row      <= next_row;
      mode     <= next_mode;
      ref_row  <= next_ref_row;
      b_act    <= next_b_act;
      b_wr     <= next_b_wr;
      b_bank   <= next_b_bank;
      b_ap     <= next_b_ap;
      b_col    <= next_b_col;
      b_cnt    <= next_b_cnt;
      p1_v     <= next_p1_v;
      p2_v     <= next_p2_v;
      p2_m     <= next_p2_m;
      p2_d     <= next_p2_d;
      o_dq     <= next_dq;
      o_dq_oe  <= next_dq_oe;
    end
  end

  // storage is not reset, so it lives outside the reset process
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    logic [7:0] mem [2**MEM_AW];
    always_ff @(posedge i_clk_sys) begin
      if (gen_v) begin
        if (gen_wr && !i_pins.dqm[lane]) begin
          mem[gen_idx] <= i_dq[lane*8 +: 8];
        end
        rd_data[lane*8 +: 8] <= mem[gen_idx];
      end
    end
  end

  assign o_bank_open    = open;
  assign o_mode         = mode;
  assign o_refresh_row  = ref_row;
  assign o_self_refresh = (pstate == sdram_pkg::ST_SELF);
  assign o_busy         = freeze || busy != '0 || recov != '0 ||
                          pstate != sdram_pkg::ST_RUN;

endmodule : sdram_device

`default_nettype wire

// file: test/sdram_device_props.sv
// Purpose: port timing checks for sdram_device
// Assumes: o_busy high marks a cycle whose command is dropped
// Notes:   burst figures fixed at cas latency 3, refresh figures at RC_CYC of 9
`timescale 1ns/1ps
`default_nettype none
module sdram_device_props (
  input wire logic                        i_clk_sys,
  input wire logic                        i_nrst,
  input wire sdram_pkg::pins_type         i_pins,
  input wire logic                        i_cke,
  input wire logic [1:0]                  o_dq_oe,
  input wire logic [1:0]                  o_bank_open,
  input wire logic [sdram_pkg::ADDR_W-1:0] o_mode,
  input wire logic [sdram_pkg::ROW_W-1:0] o_refresh_row,
  input wire logic                        o_self_refresh,
  input wire logic                        o_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic [3:0] st;
  logic       ok;
  logic       bk;
  logic       ap;
  assign st = {i_pins.cs_n, i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
  assign ok = !o_busy;
  assign bk = i_pins.addr[sdram_pkg::BANK_BIT];
  assign ap = i_pins.addr[sdram_pkg::AP_BIT];
  sequence read_go;
    ok && i_cke && st == 4'h5 && o_bank_open[bk] && i_pins.dqm == 2'h0;
  endsequence
  sequence stop_go;
    ok && i_cke && (st == 4'h6 || (st == 4'h2 && ap));
  endsequence
  sequence ref_go;
    ok && i_cke && st == 4'h1 && o_bank_open == 2'h0;
  endsequence
  rd_latency_a: assert property (
    read_go ##1 (i_cke && i_pins.dqm == 2'h0)[*2] |=> o_dq_oe == 2'h3)
    else $error("read data late");
  burst_stop_a: assert property (
    stop_go ##1 (i_cke && st[3:1] != 3'b010)[*2] |=> o_dq_oe == 2'h0)
    else $error("bus not released");
  mask_read_a: assert property (
    i_cke ##1 i_cke |=> ##1 (o_dq_oe & $past(i_pins.dqm, 2)) == 2'h0)
    else $error("masked byte driven");
  mode_load_a: assert property (
    ok && st == 4'h0 && o_bank_open == 2'h0
    |=> o_mode == $past(i_pins.addr)) else $error("mode not loaded");
  mode_guard_a: assert property (
    st == 4'h0 && o_bank_open != 2'h0 |=> $stable(o_mode))
    else $error("mode loaded with open bank");
  bank_open_a: assert property (
    ok && st == 4'h3 && !o_bank_open[bk] |=> o_bank_open[$past(bk)])
    else $error("bank not opened");
  bank_close_a: assert property (
    ok && st == 4'h2 |=> (o_bank_open
      & ($past(ap) ? 2'h3 : (2'h1 << $past(bk)))) == 2'h0)
    else $error("bank not closed");
  refresh_busy_a: assert property (
    ref_go |=> o_busy[*8]) else $error("refresh window short");
  refresh_end_a: assert property (
    ref_go ##1 (o_busy && i_cke)[*8] |=> !o_busy)
    else $error("refresh window long");
  refresh_row_a: assert property (
    ref_go |=> o_refresh_row == $past(o_refresh_row) + 1'b1)
    else $error("refresh row not stepped");
  power_freeze_a: assert property (
    !i_cke |=> o_busy) else $error("command taken while frozen");
  self_entry_a: assert property (
    ok && !i_cke && st == 4'h1 && o_bank_open == 2'h0 |=> o_self_refresh)
    else $error("self refresh not entered");
endmodule : sdram_device_props
bind sdram_device sdram_device_props u_sdram_device_props (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_pins(i_pins), .i_cke(i_cke),
  .o_dq_oe(o_dq_oe), .o_bank_open(o_bank_open), .o_mode(o_mode),
  .o_refresh_row(o_refresh_row), .o_self_refresh(o_self_refresh),
  .o_busy(o_busy));
`default_nettype wire

// file: test/sdram_ctrl_model.sv
// Purpose: controller side: command encoding and data bus resolution
// Assumes: the bench spaces commands; this model only encodes them
// Notes:   a released byte shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
  input  wire logic               i_clk_sys,
  input  wire sdram_pkg::cmd_type i_cmd,
  input  wire logic [11:0]        i_addr,
  input  wire logic [1:0]         i_dqm,
  input  wire logic               i_wen,
  input  wire logic [15:0]        i_wdata,
  input  wire logic [15:0]        i_qdata,
  input  wire logic [1:0]         i_qoe,
  output var sdram_pkg::pins_type o_pins,
  output logic [15:0]             o_bus
);
  logic [3:0]  s;
  logic [15:0] last;
  always_comb begin
    case (i_cmd)
      sdram_pkg::CMD_DESL:  s = 4'h8;
      sdram_pkg::CMD_BST:   s = 4'h6;
      sdram_pkg::CMD_READ:  s = 4'h5;
      sdram_pkg::CMD_WRITE: s = 4'h4;
      sdram_pkg::CMD_ACT:   s = 4'h3;
      sdram_pkg::CMD_PRE:   s = 4'h2;
      sdram_pkg::CMD_REF:   s = 4'h1;
      sdram_pkg::CMD_MRS:   s = 4'h0;
      default:              s = 4'h7;
    endcase
    o_pins = {s, i_dqm, i_addr};
    for (int k = 0; k < 2; k++) begin
      o_bus[8*k+:8] = i_qoe[k] ? i_qdata[8*k+:8]
                    : i_wen ? i_wdata[8*k+:8] : ~last[8*k+:8];
    end
  end
  always_ff @(posedge i_clk_sys) begin
    last <= o_bus;
  end
endmodule : sdram_ctrl_model
`default_nettype wire

// file: test/two_bank_sdram_command_timing_tb.sv
// Purpose: directed bench for sdram_device
// Assumes: inputs change on the falling edge
// Notes:   command spacing is chosen by the bench, not checked by the device
`timescale 1ns/1ps
`default_nettype none
module two_bank_sdram_command_timing_tb;
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic                cke = 1'b0;
  logic                wen = 1'b0;
  logic [1:0]          dqm = 2'h0;
  logic [11:0]         addr = 12'h000;
  logic [15:0]         wd = 16'h0000;
  sdram_pkg::cmd_type  cmd = sdram_pkg::CMD_NOP;
  sdram_pkg::pins_type pins;
  logic [15:0]         bus;
  logic [15:0]         q;
  logic [1:0]          qoe;
  logic [1:0]          bopen;
  logic [11:0]         mode;
  logic [10:0]         rrow;
  logic                sref;
  logic                busy;
  int                  err_count = 0;
  int                  n_tests = 0;
  int                  cycles = 0;
  always #20 clk = ~clk;
  sdram_device #(.BURST_LEN(4), .ROW_USE(2)) u_sdram_device (
    .i_clk_sys(clk), .i_nrst(nrst), .i_pins(pins), .i_cke(cke), .i_dq(bus),
    .o_dq(q), .o_dq_oe(qoe), .o_bank_open(bopen), .o_mode(mode),
    .o_refresh_row(rrow), .o_self_refresh(sref), .o_busy(busy));
  sdram_ctrl_model u_sdram_ctrl_model (
    .i_clk_sys(clk), .i_cmd(cmd), .i_addr(addr), .i_dqm(dqm), .i_wen(wen),
    .i_wdata(wd), .i_qdata(q), .i_qoe(qoe), .o_pins(pins), .o_bus(bus));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // command in one cycle, then n idle cycles; the next call lands after them
  task automatic go(input sdram_pkg::cmd_type c, input logic [11:0] a,
                    input int n);
    @(negedge clk);
    cmd = c;
    addr = a;
    repeat (n) begin
      @(negedge clk);
      cmd = sdram_pkg::CMD_NOP;
    end
  endtask : go
  task automatic wr(input logic [15:0] d, input int m);
    for (int k = 0; k < 5; k++) begin
      @(negedge clk);
      cmd = (k == 0) ? sdram_pkg::CMD_WRITE : sdram_pkg::CMD_NOP;
      wen = (k < 4);
      wd = d + 16'(k);
      dqm = (k == m) ? 2'b10 : 2'b00;
    end
  endtask : wr
  task automatic t_banks();
    go(sdram_pkg::CMD_MRS, 12'h123, 2);
    chk(mode, 12'h123);
    go(sdram_pkg::CMD_ACT, 12'h805, 2);
    chk(bopen, 2'b10);
    go(sdram_pkg::CMD_ACT, 12'h005, 2);
    go(sdram_pkg::CMD_MRS, 12'h0FF, 2);
    chk({bopen, mode}, {2'b11, 12'h123});
    go(sdram_pkg::CMD_PRE, 12'h800, 2);
    chk(bopen, 2'b01);
    go(sdram_pkg::CMD_PRE, 12'h400, 3);
    chk(bopen, 2'b00);
    $display("banks done");
  endtask : t_banks
  task automatic t_rw();
    logic [15:0] e [5] = '{16'h2220, 16'h2222, 16'h2223, 16'h2220, 16'h1121};
    go(sdram_pkg::CMD_ACT, 12'h000, 2);
    wr(16'h1110, 5);
    wr(16'h2220, 1);
    go(sdram_pkg::CMD_READ, 12'h000, 0);
    go(sdram_pkg::CMD_READ, 12'h002, 1);
    foreach (e[i]) begin
      @(negedge clk);
      chk(q, e[i]);
    end
    @(negedge clk);
    chk(qoe, 2'b00);
    go(sdram_pkg::CMD_READ, 12'h400, 1);
    chk(bopen, 2'b01);
    repeat (5) @(negedge clk);
    chk(bopen, 2'b00);
    $display("write read done");
  endtask : t_rw
  task automatic t_stop();
    go(sdram_pkg::CMD_ACT, 12'h000, 5);
    go(sdram_pkg::CMD_READ, 12'h000, 0);
    @(negedge clk);
    cmd = sdram_pkg::CMD_BST;
    dqm = 2'b01;
    @(negedge clk);
    cmd = sdram_pkg::CMD_NOP;
    dqm = 2'b00;
    @(negedge clk);
    chk({qoe, q[15:8]}, {2'b10, 8'h22});
    @(negedge clk);
    chk(qoe, 2'b00);
    go(sdram_pkg::CMD_READ, 12'h000, 0);
    go(sdram_pkg::CMD_PRE, 12'h400, 1);
    @(negedge clk);
    chk(qoe, 2'b11);
    @(negedge clk);
    chk({qoe, bopen}, 4'h0);
    $display("stop done");
  endtask : t_stop
  task automatic t_power();
    logic [10:0] v;
    v = rrow;
    go(sdram_pkg::CMD_REF, 12'h000, 1);
    chk(busy, 1'b1);
    repeat (7) @(negedge clk);
    chk(busy, 1'b1);
    @(negedge clk);
    chk({busy, rrow}, {1'b0, v + 11'h001});
    go(sdram_pkg::CMD_ACT, 12'h800, 2);
    cke = 1'b0;
    repeat (3) @(negedge clk);
    chk(busy, 1'b1);
    cke = 1'b1;
    @(negedge clk);
    chk(busy, 1'b1);
    @(negedge clk);
    chk({busy, bopen}, {1'b0, 2'b10});
    go(sdram_pkg::CMD_PRE, 12'h400, 3);
    @(negedge clk);
    cmd = sdram_pkg::CMD_REF;
    cke = 1'b0;
    @(negedge clk);
    cmd = sdram_pkg::CMD_NOP;
    chk(sref, 1'b1);
    repeat (4) @(negedge clk);
    cke = 1'b1;
    repeat (8) @(negedge clk);
    chk(busy, 1'b1);
    @(negedge clk);
    chk({busy, sref}, 2'b00);
    $display("power done");
  endtask : t_power
  task automatic t_suspend();
    logic [15:0] e [3] = '{16'h1121, 16'h2222, 16'h2223};
    go(sdram_pkg::CMD_ACT, 12'h000, 2);
    go(sdram_pkg::CMD_READ, 12'h000, 1);
    @(negedge clk);
    cke = 1'b0;
    repeat (3) @(negedge clk);
    chk(q, 16'h2220);
    chk(qoe, 2'b11);
    // the burst must resume where it stopped, not skip words
    cke = 1'b1;
    @(negedge clk);
    chk(q, 16'h2220);
    chk(busy, 1'b1);
    foreach (e[i]) begin
      @(negedge clk);
      chk(q, e[i]);
    end
    @(negedge clk);
    chk(qoe, 2'b00);
    go(sdram_pkg::CMD_PRE, 12'h400, 2);
    go(sdram_pkg::CMD_DESL, 12'h0AA, 2);
    chk(mode, 12'h123);
    $display("suspend done");
  endtask : t_suspend
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    cke = 1'b1;
    repeat (2) @(negedge clk);
    t_banks();
    t_rw();
    t_stop();
    t_power();
    t_suspend();
    complete_run();
  end
endmodule : two_bank_sdram_command_timing_tb
`default_nettype wire
